/* File: core/cmm_map.svh */
// Address map, register offsets, field positions and reset values of the control block
`ifndef CMM_MAP_SVH
`define CMM_MAP_SVH
`define CMM_OFF_PSW 12'h000
`define CMM_OFF_SP 12'h004
`define CMM_OFF_PC 12'h008
`define CMM_OFF_CFG 12'h00C
`define CMM_PSW_RST 8'h02
`define CMM_SP_RST 16'h0000
`define CMM_PC_RST 16'h0000
`define CMM_CFG_RST 8'h06
`define CMM_B_GIE 7
`define CMM_B_Z 6
`define CMM_B_BSH 5
`define CMM_B_HC 4
`define CMM_B_BSL 3
`define CMM_B_ZERO 2
`define CMM_B_INSV 1
`define CMM_B_CARRY 0
`define CMM_VEC_LO 16'h0000
`define CMM_VEC_HI 16'h0001
`define CMM_DBG_LO 16'h0085
`define CMM_DBG_HI 16'h008E
`define CMM_DBGM_LO 16'h1085
`define CMM_DBGM_HI 16'h108E
`define CMM_EDGE 16'h7FFF
`define CMM_WIN_LO 16'h8000
`define CMM_WIN_HI 16'hBFFF
`define CMM_PHYS_WIN 17'h0_8000
`define CMM_EXP_HI 16'hF7FF
`define CMM_EXP_LO3 16'hF400
`define CMM_EXP_LO4 16'hF000
`define CMM_EXP_LO5 16'hE800
`define CMM_EXP_LO6 16'hE000
`define CMM_HS_LO_S 16'hFC00
`define CMM_HS_LO 16'hFB00
`define CMM_HS_HI 16'hFEFF
`define CMM_GPR_LO 16'hFEE0
`define CMM_SFR_LO 16'hFF00
`define CMM_ROM_TOP0 16'h3FFF
`define CMM_ROM_TOP1 16'h5FFF
`define CMM_ROM_TOP2 16'h7FFF
`define CMM_ROM_TOP3 16'hBFFF
`define CMM_ROM_TOP4 16'hEFFF
`define CMM_NBANK5 3'h4
`define CMM_NBANK6 3'h6
`define CMM_VAR_BANK4 3'h5
`define CMM_VAR_DBG 3'h6
`define CMM_VAR_EXP 3'h3
`endif

/* File: core/cmm_pkg.sv */
// Types shared by the control block files
package cmm_pkg;
    typedef enum logic [3:0] {
        CMM_VEC_RD_LO = 4'b0001,
        CMM_VEC_RD_HI = 4'b0010,
        CMM_VEC_LOAD = 4'b0100,
        CMM_RUN = 4'b1000
    } cmm_boot_e;
    typedef enum logic [2:0] {
        CMM_RG_NONE = 3'h0,
        CMM_RG_ROM = 3'h1,
        CMM_RG_DBG = 3'h2,
        CMM_RG_BANK = 3'h3,
        CMM_RG_EXP = 3'h4,
        CMM_RG_HS = 3'h5,
        CMM_RG_GPR = 3'h6,
        CMM_RG_SFR = 3'h7
    } cmm_region_e;
endpackage

/* File: core/cmm_gpr_ram.sv */
// General register bank storage, 4 banks of 8 bytes, registered read
`timescale 1ns/100ps
module cmm_gpr_ram (
    input wire logic clk, // System clock
    input wire logic we, // Write strobe
    input wire logic [4:0] addr, // Bank and register index
    input wire logic [7:0] wdata, // Write data
    output logic [7:0] rdata_q // Read data, one cycle after addr
);
    logic [7:0] mem [0:31];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem[addr];
    end
endmodule

/* File: core/cmm_ctrl_regs.sv */
// Address decode, status word, stack pointer and program counter of the CPU
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "cmm_map.svh"
module cmm_ctrl_regs import cmm_pkg::*; (
    input wire logic clk, // 25 MHz clock
    input wire logic reset_n, // Synchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata_q, // APB read data
    output logic pready_q, // APB ready
    output logic pslverr_q, // APB error
    output logic vec_rd_q, // Vector read strobe
    output logic [15:0] vec_addr_q, // Vector read address
    input wire logic [7:0] vec_data, // Vector byte, same cycle as strobe
    output logic run_q, // CPU may run
    input wire logic cpu_req, // Address decode request
    input wire logic cpu_fetch, // Request is an instruction fetch
    input wire logic cpu_cont, // Byte continues previous instruction
    input wire logic [15:0] cpu_addr, // Logical address
    output logic dec_valid_q, // Decode result valid
    output logic [2:0] region_q, // Region code
    output logic [16:0] phys_q, // Physical code address
    output logic fault_q, // Illegal access
    input wire logic pc_adv, // Advance program counter
    input wire logic [2:0] pc_len, // Instruction length
    input wire logic branch, // Branch taken
    input wire logic [15:0] branch_target, // Branch target
    output logic [15:0] pc_q, // Program counter
    input wire logic flag_we, // Update result flags
    input wire logic [7:0] alu_result, // Operation result
    input wire logic alu_c3, // Carry or borrow at bit 3
    input wire logic alu_cy, // Carry, shift-out or bit value
    input wire logic mask_all_instruction, // Clear enable
    input wire logic unmask_all_instruction, // Set enable
    input wire logic register_bank_switch_instruction, // Select bank
    input wire logic [1:0] bank_val, // Bank to select
    input wire logic psw_push, // Push status word
    input wire logic psw_restore, // Pop or return restores status
    input wire logic [7:0] psw_pop_data, // Status read from stack
    input wire logic stk_push, // Other one-byte push
    input wire logic stk_pop, // Other one-byte pop
    input wire logic irq_req, // Maskable request
    input wire logic irq_low, // Request is low priority
    output logic irq_take_q, // Request accepted
    output logic [7:0] processor_status_word, // Status word
    output logic [15:0] stack_pointer, // Stack pointer
    output logic stk_we_q, // Status save strobe
    output logic [15:0] stk_addr_q, // Stack byte address
    output logic [7:0] stk_wdata_q, // Saved status
    output logic stk_err_q, // Stack outside high-speed RAM
    input wire logic gpr_we, // General register write
    input wire logic [2:0] gpr_idx, // Register in bank
    input wire logic [7:0] gpr_wdata, // Register write data
    output logic [7:0] gpr_rdata_q // Register read data
);
    logic [7:0] psw_q;
    logic [15:0] sp_q;
    logic [7:0] cfg_q;
    logic [7:0] vec_lo_q;
    logic edge_q;
    cmm_boot_e state_q;
    cmm_region_e region_d;
    logic [15:0] hs_lo, exp_lo, rom_top, sp_dec;
    logic [2:0] nbanks, variant, bank;
    logic has_exp, banked, boot_swap, straddle, fault_d, push_any, pop_any;
    logic setup, acc, wr_psw, wr_sp, wr_cfg;

    assign variant = cfg_q[2:0];
    assign boot_swap = cfg_q[3];
    assign bank = cfg_q[6:4];
    assign processor_status_word = psw_q;
    assign stack_pointer = sp_q;
    assign push_any = psw_push | irq_take_q | stk_push;
    assign pop_any = psw_restore | stk_pop;
    assign sp_dec = sp_q - 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one access cycle
    assign setup = psel & ~penable;
    assign acc = psel & penable & pready_q;
    assign wr_psw = acc & pwrite & (paddr == `CMM_OFF_PSW);
    assign wr_sp = acc & pwrite & (paddr == `CMM_OFF_SP);
    assign wr_cfg = acc & pwrite & (paddr == `CMM_OFF_CFG);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= 1'b0;
            if (setup) begin
                prdata_q <= 32'h0000_0000;
                unique case (paddr)
                    `CMM_OFF_PSW: prdata_q[7:0] <= psw_q;
                    `CMM_OFF_SP: prdata_q[15:0] <= sp_q;
                    `CMM_OFF_PC: begin
                        prdata_q[15:0] <= pc_q;
                        pslverr_q <= pwrite;
                    end
                    `CMM_OFF_CFG: prdata_q[7:0] <= cfg_q;
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_q <= `CMM_CFG_RST;
        end else if (wr_cfg) begin
            cfg_q <= {1'b0, pwdata[6:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset vector fetch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= CMM_VEC_RD_LO;
            vec_rd_q <= 1'b0;
            vec_addr_q <= `CMM_VEC_LO;
            vec_lo_q <= 8'h00;
            run_q <= 1'b0;
        end else begin
            unique case (state_q)
                CMM_VEC_RD_LO: begin
                    vec_rd_q <= 1'b1;
                    vec_addr_q <= `CMM_VEC_LO;
                    state_q <= CMM_VEC_RD_HI;
                end
                CMM_VEC_RD_HI: begin
                    vec_addr_q <= `CMM_VEC_HI;
                    vec_lo_q <= vec_data;
                    state_q <= CMM_VEC_LOAD;
                end
                CMM_VEC_LOAD: begin
                    vec_rd_q <= 1'b0;
                    state_q <= CMM_RUN;
                    run_q <= 1'b1;
                end
                CMM_RUN: begin
                    vec_rd_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pc_q <= `CMM_PC_RST;
        end else if (state_q == CMM_VEC_LOAD) begin
            pc_q <= {vec_data, vec_lo_q};
        end else if (branch) begin
            pc_q <= branch_target;
        end else if (pc_adv) begin
            pc_q <= pc_q + {13'h0000, pc_len};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word; later assignments win
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            psw_q <= `CMM_PSW_RST;
        end else begin
            if (wr_psw) begin
                psw_q <= pwdata[7:0];
            end
            if (psw_restore) begin
                psw_q <= psw_pop_data;
            end
            if (flag_we) begin
                psw_q[`CMM_B_Z] <= (alu_result == 8'h00);
                psw_q[`CMM_B_HC] <= alu_c3;
                psw_q[`CMM_B_CARRY] <= alu_cy;
            end
            if (register_bank_switch_instruction) begin
                psw_q[`CMM_B_BSH] <= bank_val[1];
                psw_q[`CMM_B_BSL] <= bank_val[0];
            end
            if (unmask_all_instruction) begin
                psw_q[`CMM_B_GIE] <= 1'b1;
            end
            if (mask_all_instruction | irq_take_q) begin
                psw_q[`CMM_B_GIE] <= 1'b0;
            end
            psw_q[`CMM_B_ZERO] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt acceptance
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_take_q <= 1'b0;
        end else begin
            irq_take_q <= run_q & irq_req & ~irq_take_q & psw_q[`CMM_B_GIE]
                & (psw_q[`CMM_B_INSV] | ~irq_low);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer and status save
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sp_q <= `CMM_SP_RST;
            stk_we_q <= 1'b0;
            stk_addr_q <= `CMM_SP_RST;
            stk_wdata_q <= 8'h00;
            stk_err_q <= 1'b0;
        end else begin
            stk_we_q <= psw_push | irq_take_q;
            stk_wdata_q <= psw_q;
            stk_err_q <= 1'b0;
            if (wr_sp) begin
                sp_q <= pwdata[15:0];
            end
            if (push_any) begin
                sp_q <= sp_dec;
                stk_addr_q <= sp_dec;
                stk_err_q <= (sp_dec < hs_lo) | (sp_dec > `CMM_HS_HI);
            end else if (pop_any) begin
                sp_q <= sp_q + 16'h0001;
                stk_addr_q <= sp_q;
                stk_err_q <= (sp_q < hs_lo) | (sp_q > `CMM_HS_HI);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb begin
        hs_lo = (variant == 3'h0) ? `CMM_HS_LO_S : `CMM_HS_LO;
        has_exp = (variant >= `CMM_VAR_EXP);
        banked = (variant >= `CMM_VAR_BANK4);
        nbanks = (variant == `CMM_VAR_BANK4) ? `CMM_NBANK5 : `CMM_NBANK6;
        unique case (variant)
            3'h0: rom_top = `CMM_ROM_TOP0;
            3'h1: rom_top = `CMM_ROM_TOP1;
            3'h2: rom_top = `CMM_ROM_TOP2;
            3'h3: rom_top = `CMM_ROM_TOP3;
            3'h4: rom_top = `CMM_ROM_TOP4;
            default: rom_top = `CMM_ROM_TOP2;
        endcase
        unique case (variant)
            3'h3: exp_lo = `CMM_EXP_LO3;
            3'h4: exp_lo = `CMM_EXP_LO4;
            3'h5: exp_lo = `CMM_EXP_LO5;
            default: exp_lo = `CMM_EXP_LO6;
        endcase
        region_d = CMM_RG_NONE;
        if (cpu_addr >= `CMM_SFR_LO) begin
            region_d = CMM_RG_SFR;
        end else if (cpu_addr >= `CMM_GPR_LO) begin
            region_d = CMM_RG_GPR;
        end else if (cpu_addr >= hs_lo) begin
            region_d = CMM_RG_HS;
        end else if (has_exp && cpu_addr >= exp_lo && cpu_addr <= `CMM_EXP_HI) begin
            region_d = CMM_RG_EXP;
        end else if (variant == `CMM_VAR_DBG && ((cpu_addr >= `CMM_DBG_LO
                && cpu_addr <= `CMM_DBG_HI) || (boot_swap && cpu_addr >= `CMM_DBGM_LO
                && cpu_addr <= `CMM_DBGM_HI))) begin
            region_d = CMM_RG_DBG;
        end else if (banked && cpu_addr >= `CMM_WIN_LO && cpu_addr <= `CMM_WIN_HI) begin
            region_d = CMM_RG_BANK;
        end else if (cpu_addr <= rom_top) begin
            region_d = CMM_RG_ROM;
        end
        straddle = cpu_fetch & cpu_cont & edge_q & (cpu_addr == `CMM_WIN_LO)
            & banked & (bank != 3'h0);
        fault_d = (region_d == CMM_RG_NONE)
            | ((region_d == CMM_RG_BANK) & (bank >= nbanks))
            | (cpu_fetch & (region_d == CMM_RG_GPR))
            | straddle;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dec_valid_q <= 1'b0;
            region_q <= CMM_RG_NONE;
            phys_q <= 17'h0_0000;
            fault_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            dec_valid_q <= cpu_req;
            if (cpu_req) begin
                region_q <= region_d;
                fault_q <= fault_d;
                phys_q <= (region_d == CMM_RG_BANK)
                    ? `CMM_PHYS_WIN + {bank, cpu_addr[13:0]}
                    : {1'b0, cpu_addr};
                if (cpu_fetch) begin
                    edge_q <= (cpu_addr == `CMM_EDGE);
                end
            end
        end
    end

    cmm_gpr_ram u_gpr (
        .clk(clk),
        .we(gpr_we),
        .addr({psw_q[`CMM_B_BSH], psw_q[`CMM_B_BSL], gpr_idx}),
        .wdata(gpr_wdata),
        .rdata_q(gpr_rdata_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    psw_reset_a: assert property (@(posedge clk)
        !reset_n |=> psw_q == `CMM_PSW_RST) else $error("status reset value wrong");
    vec_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == CMM_VEC_LOAD |=> pc_q == {$past(vec_data), $past(vec_lo_q)})
        else $error("vector not loaded");
    gie_refuse_a: assert property (@(posedge clk) disable iff (!reset_n)
        !psw_q[`CMM_B_GIE] |=> !irq_take_q) else $error("request taken while disabled");
    low_prio_a: assert property (@(posedge clk) disable iff (!reset_n)
        irq_take_q |-> $past(psw_q[`CMM_B_INSV] | ~irq_low)) else $error("low priority taken");
    gie_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        (irq_take_q | mask_all_instruction) |=> !psw_q[`CMM_B_GIE]) else $error("enable kept");
    zero_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        flag_we |=> psw_q[`CMM_B_Z] == ($past(alu_result) == 8'h00)) else $error("zero flag");
    carry_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
        flag_we |=> psw_q[`CMM_B_HC] == $past(alu_c3) && psw_q[`CMM_B_CARRY] == $past(alu_cy))
        else $error("carry flags wrong");
    sp_push_a: assert property (@(posedge clk) disable iff (!reset_n)
        push_any |=> sp_q == $past(sp_q) - 16'h0001 && stk_addr_q == sp_q)
        else $error("stack predecrement wrong");
    pc_adv_a: assert property (@(posedge clk) disable iff (!reset_n)
        run_q && pc_adv && !branch |=> pc_q == $past(pc_q) + {13'h0000, $past(pc_len)})
        else $error("pc advance wrong");
    gpr_fetch_a: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_req && cpu_fetch && region_d == CMM_RG_GPR |=> fault_q && dec_valid_q)
        else $error("register area fetch allowed");
    bank_map_a: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_req && region_d == CMM_RG_BANK |=> phys_q[16:14] == $past(bank) + 3'h2)
        else $error("bank mapping wrong");
    straddle_a: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_req && straddle |=> fault_q) else $error("straddle not refused");
    irq_cov: cover property (@(posedge clk) disable iff (!reset_n) irq_take_q ##1 stk_we_q);
    bank_cov: cover property (@(posedge clk) disable iff (!reset_n)
        dec_valid_q && region_q == CMM_RG_BANK && !fault_q);
    boot_cov: cover property (@(posedge clk) disable iff (!reset_n) $rose(run_q));
endmodule

/* File: verification/cmm_vec_rom.sv */
// Vector ROM model that answers the boot reads of the control block
`timescale 1ns/100ps
module cmm_vec_rom (
    input wire logic clk, // System clock
    input wire logic vec_rd_q, // Boot read strobe
    input wire logic [15:0] vec_addr_q, // Vector byte address
    output logic [7:0] vec_data // Byte in the same cycle as address
);
    // Byte follows the registered address; idle bus shows inverse of last byte
    always_comb begin
        vec_data = 8'hED;
        if (vec_rd_q && vec_addr_q == 16'h0000) begin
            vec_data = 8'h34;
        end else if (vec_rd_q && vec_addr_q == 16'h0001) begin
            vec_data = 8'h12;
        end
    end
endmodule

/* File: verification/cmm_ctrl_regs_test.sv */
// Self-checking bench for the control block
`timescale 1ns/100ps
`include "cmm_map.svh"
module cmm_ctrl_regs_test import cmm_pkg::*;;
    logic clk, reset_n, psel, penable, pwrite, cpu_req, cpu_fetch, cpu_cont, pc_adv, branch;
    logic flag_we, alu_c3, alu_cy, mask_all_instruction, unmask_all_instruction;
    logic register_bank_switch_instruction, psw_push, stk_push, stk_pop, irq_req, irq_low;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_q, rd;
    logic [15:0] cpu_addr, branch_target, vec_addr_q, pc_q, stack_pointer, stk_addr_q;
    logic [7:0] alu_result, vec_data, processor_status_word, stk_wdata_q, gpr_rdata_q;
    logic [2:0] pc_len, region_q;
    logic [1:0] bank_val;
    logic [16:0] phys_q;
    logic pready_q, pslverr_q, vec_rd_q, run_q, dec_valid_q, fault_q, irq_take_q, stk_we_q;
    logic stk_err_q, er;
    logic psw_restore, gpr_we;
    logic [7:0] psw_pop_data, gpr_wdata;
    logic [2:0] gpr_idx;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    logic [15:0] ta [7] = '{16'h0085, 16'h108E, 16'h8000, 16'hFB00, 16'hFEE0, 16'hE000, 16'hFF00};
    logic [2:0] tr [7] = '{CMM_RG_DBG, CMM_RG_DBG, CMM_RG_BANK, CMM_RG_HS, CMM_RG_GPR,
        CMM_RG_EXP, CMM_RG_SFR};
    logic [6:0] tfe = 7'h30;
    logic [6:0] tfl = 7'h10;

    cmm_ctrl_regs dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
        .pready_q, .pslverr_q, .vec_rd_q, .vec_addr_q, .vec_data, .run_q, .cpu_req, .cpu_fetch,
        .cpu_cont, .cpu_addr, .dec_valid_q, .region_q, .phys_q, .fault_q, .pc_adv, .pc_len,
        .branch, .branch_target, .pc_q, .flag_we, .alu_result, .alu_c3, .alu_cy,
        .mask_all_instruction, .unmask_all_instruction, .register_bank_switch_instruction,
        .bank_val, .psw_push, .psw_restore, .psw_pop_data, .stk_push, .stk_pop,
        .irq_req, .irq_low, .irq_take_q, .processor_status_word, .stack_pointer, .stk_we_q,
        .stk_addr_q, .stk_wdata_q, .stk_err_q, .gpr_we, .gpr_idx, .gpr_wdata, .gpr_rdata_q);
    cmm_vec_rom rom (.clk, .vec_rd_q, .vec_addr_q, .vec_data);

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            tally_and_finish;
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One edge, then drop every one-cycle request
    task step;
        @(posedge clk);
        {cpu_req, pc_adv, branch, flag_we, mask_all_instruction, unmask_all_instruction} <= '0;
        {register_bank_switch_instruction, psw_push, stk_push, stk_pop, irq_req} <= '0;
        {psw_restore, gpr_we} <= '0;
        #1;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready_q !== 1'h1) @(posedge clk);
        rd = prdata_q;
        er = pslverr_q;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task dec(input logic [15:0] a, input logic f, input logic c);
        cpu_req <= 1'h1;
        cpu_addr <= a;
        cpu_fetch <= f;
        cpu_cont <= c;
        step;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, reset_n, psel, penable, pwrite, paddr, pwdata, cpu_addr, branch_target} = '0;
        {cpu_req, cpu_fetch, cpu_cont, pc_adv, branch, flag_we, alu_c3, alu_cy} = '0;
        {mask_all_instruction, unmask_all_instruction, register_bank_switch_instruction} = '0;
        {psw_push, stk_push, stk_pop, irq_req, irq_low, alu_result, pc_len, bank_val} = '0;
        {psw_restore, psw_pop_data, gpr_we, gpr_idx, gpr_wdata} = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        repeat (5) step;
        chk("run", 32'h1, run_q);
        chk("pc", 32'h1234, pc_q);
        apb(1'h0, `CMM_OFF_PSW, 32'h0);
        chk("psw", 32'h0000_0002, rd);
        apb(1'h1, `CMM_OFF_SP, 32'h0000_FEE0);
        apb(1'h0, `CMM_OFF_SP, 32'h0);
        chk("sp", 32'h0000_FEE0, rd);
        apb(1'h1, `CMM_OFF_PC, 32'h0000_0055);
        chk("pc_wr_err", 32'h1, er);
        chk("pc_kept", 32'h1234, pc_q);
        stk_push <= 1'h1;
        step;
        chk("sp_push", 32'hFEDF, stack_pointer);
        stk_pop <= 1'h1;
        step;
        chk("sp_pop", 32'hFEE0, stack_pointer);
        pc_adv <= 1'h1;
        pc_len <= 3'h3;
        step;
        chk("pc_adv", 32'h1237, pc_q);
        {pc_adv, branch, branch_target} <= {2'h3, 16'hE000};
        step;
        chk("pc_branch", 32'hE000, pc_q);
        {flag_we, alu_result, alu_c3, alu_cy} <= {1'h1, 8'h00, 2'h3};
        step;
        chk("flags_set", 32'h53, processor_status_word);
        {flag_we, alu_result, alu_c3, alu_cy} <= {1'h1, 8'h01, 2'h0};
        step;
        chk("flags_clr", 32'h02, processor_status_word);
        for (int b = 0; b < 4; b++) begin
            register_bank_switch_instruction <= 1'h1;
            bank_val <= b[1:0];
            step;
            chk("bank", 32'h02 | b[1] << 5 | b[0] << 3, processor_status_word);
        end
        irq_req <= 1'h1;
        step;
        chk("irq_gie0", 32'h0, irq_take_q);
        unmask_all_instruction <= 1'h1;
        step;
        chk("gie_set", 32'h1, processor_status_word[7]);
        apb(1'h1, `CMM_OFF_PSW, 32'h0000_0080);
        {irq_req, irq_low} <= 2'h3;
        step;
        chk("irq_low", 32'h0, irq_take_q);
        {irq_req, irq_low} <= 2'h2;
        step;
        chk("irq_take", 32'h1, irq_take_q);
        step;
        chk("gie_acc", 32'h00, processor_status_word);
        chk("psw_save", 32'h1, stk_we_q);
        chk("save_adr", 32'hFEDF, stk_addr_q);
        chk("save_dat", 32'h80, stk_wdata_q);
        unmask_all_instruction <= 1'h1;
        step;
        mask_all_instruction <= 1'h1;
        step;
        chk("gie_clr", 32'h0, processor_status_word[7]);
        psw_push <= 1'h1;
        step;
        chk("push_sp", 32'hFEDE, stack_pointer);
        {psw_restore, psw_pop_data} <= {1'h1, 8'hF3};
        step;
        chk("psw_pop", 32'hF3, processor_status_word);
        chk("pop_sp", 32'hFEDF, stack_pointer);
        {gpr_we, gpr_idx, gpr_wdata} <= {1'h1, 3'h5, 8'hA7};
        step;
        {register_bank_switch_instruction, bank_val} <= 3'h5;
        step;
        {gpr_we, gpr_wdata} <= {1'h1, 8'h5C};
        step;
        step;
        chk("gpr_bank1", 32'h5C, gpr_rdata_q);
        {register_bank_switch_instruction, bank_val} <= 3'h6;
        step;
        step;
        chk("gpr_bank2", 32'hA7, gpr_rdata_q);
        apb(1'h1, `CMM_OFF_CFG, 32'h0000_000E);
        for (int i = 0; i < 7; i++) begin
            dec(ta[i], tfe[i], 1'h0);
            chk("region", tr[i], region_q);
            chk("fault", tfl[i], fault_q);
        end
        dec(16'h7FFF, 1'h1, 1'h0);
        dec(16'h8000, 1'h1, 1'h1);
        chk("straddle0", 32'h0, fault_q);
        apb(1'h1, `CMM_OFF_CFG, 32'h0000_005E);
        dec(16'h8000, 1'h0, 1'h0);
        chk("phys", 32'h0001_C000, phys_q);
        dec(16'h7FFF, 1'h1, 1'h0);
        dec(16'h8000, 1'h1, 1'h1);
        chk("straddle5", 32'h1, fault_q);
        apb(1'h1, `CMM_OFF_CFG, 32'h0000_006E);
        dec(16'h8000, 1'h0, 1'h0);
        chk("bank_over", 32'h1, fault_q);
        apb(1'h1, `CMM_OFF_SP, 32'h0000_E001);
        stk_push <= 1'h1;
        step;
        chk("stk_exp", 32'h1, stk_err_q);
        apb(1'h0, 12'h0F0, 32'h0);
        chk("unmapped", 32'h1, er);
        tally_and_finish;
    end
endmodule
